// ===== design/status_pkg.sv
package status_pkg;
  localparam logic [15:0] ADDR_GUARD_LOW = 16'h0001;
  localparam logic [15:0] ADDR_GUARD_HIGH = 16'h0002;
  localparam logic [15:0] ADDR_FAULT_POS = 16'h0003;
  localparam logic [15:0] ADDR_SW_COUNT = 16'h0004;
  localparam logic [7:0] FUNC_READ_HOLDING = 8'h03;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam int NUM_SWITCHES = 20;
  localparam int CLK_HZ = 100_000_000;
  localparam int FRAME_TIMEOUT_S = 3;
  localparam longint FRAME_TIMEOUT_CYC = longint'(FRAME_TIMEOUT_S) * longint'(CLK_HZ);
  localparam int INIT_CYCLES = 7;
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_RUN = 2'b01,
    ST_ERROR = 2'b10
  } mode_t;
endpackage : status_pkg

// ===== design/status_word_if.sv
interface status_word_if;
  logic [15:0] guard_low;
  logic [15:0] guard_high;
  logic [15:0] fault_pos;
  logic [15:0] sw_count;
  modport source (output guard_low, output guard_high, output fault_pos, output sw_count);
  modport sink (input guard_low, input guard_high, input fault_pos, input sw_count);
endinterface : status_word_if

// ===== design/status_word_store.sv
module status_word_store (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_load,
  input wire logic i_error,
  input wire logic [19:0] i_closed,
  input wire logic [4:0] i_fault_pos,
  input wire logic i_count_load,
  input wire logic [4:0] i_count,
  status_word_if.source words
);
  logic [15:0] guard_low;
  logic [15:0] guard_high;
  logic [15:0] fault_pos;
  logic [15:0] sw_count;
  wire [19:0] shown_closed = i_error ? 20'h0_0000 : i_closed;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      guard_low <= status_pkg::WORD_RESET;
      guard_high <= status_pkg::WORD_RESET;
      fault_pos <= status_pkg::WORD_RESET;
      sw_count <= status_pkg::WORD_RESET;
    end else begin
      if (i_load || i_error) begin
        guard_low <= shown_closed[15:0];
        guard_high <= {12'h000, shown_closed[19:16]};
        fault_pos <= {11'h000, i_fault_pos};
      end
      if (i_count_load) begin
        sw_count <= {11'h000, i_count};
      end
    end
  end
  assign words.guard_low = guard_low;
  assign words.guard_high = guard_high;
  assign words.fault_pos = fault_pos;
  assign words.sw_count = sw_count;
endmodule : status_word_store

// ===== design/safety_chain_status_regs.sv
module safety_chain_status_regs #(
  parameter longint TIMEOUT_CYC = status_pkg::FRAME_TIMEOUT_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [4:0] i_dip_count,
  input wire logic i_frame_valid,
  input wire logic i_frame_bad,
  input wire logic [19:0] i_frame_closed,
  input wire logic [4:0] i_frame_fault_pos,
  input wire logic i_req_valid,
  input wire logic [7:0] i_req_func,
  input wire logic [15:0] i_req_addr,
  output logic o_rsp_valid,
  output logic o_rsp_exception,
  output logic [15:0] o_rsp_data,
  output logic o_error_mode
);

  // Words live in the store; this module decodes and answers
  status_word_if words();

  // Operating mode
  status_pkg::mode_t mode;
  status_pkg::mode_t next_mode;
  logic error_mode;

  // DIP pins come from outside the clock domain
  logic [2:0] dip_sync [0:4];
  logic [4:0] dip_stable;

  // Start-up delay and frame watchdog
  logic [2:0] init_cnt;
  logic [2:0] next_init_cnt;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic [31:0] timer_limit;

  // Response registers
  logic rsp_valid;
  logic rsp_exception;
  logic [15:0] rsp_data;
  logic next_rsp_exception;
  logic [15:0] next_rsp_data;

  // Named decode wires
  logic init_done;
  logic timed_out;
  logic frame_ok;
  logic frame_fail;
  logic frame_lost;
  logic in_init;
  logic in_run;
  logic in_error;
  logic entering_error;
  logic store_load;
  logic store_error;
  logic count_load;
  logic func_ok;
  logic addr_ok;
  logic req_ok;
  logic [15:0] sel_word;

  // Three-stage sync; value accepted when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_dip
      wire dip_agree = dip_sync[g][2] == dip_sync[g][1];
      always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          dip_sync[g] <= 3'h0;
        end else begin
          dip_sync[g] <= {dip_sync[g][1:0], i_dip_count[g]};
        end
      end
      always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          dip_stable[g] <= 1'b0;
        end else if (dip_agree) begin
          dip_stable[g] <= dip_sync[g][2];
        end
      end
    end
  endgenerate

  // Map decode for the exception flag and the data path
  function automatic logic in_map(input logic [15:0] addr);
    in_map = addr >= status_pkg::ADDR_GUARD_LOW && addr <= status_pkg::ADDR_SW_COUNT;
  endfunction : in_map

  function automatic logic [15:0] read_word(input logic [15:0] addr, input logic [15:0] w1,
    input logic [15:0] w2, input logic [15:0] w3, input logic [15:0] w4);
    case (addr)
      status_pkg::ADDR_GUARD_LOW: read_word = w1;
      status_pkg::ADDR_GUARD_HIGH: read_word = w2;
      status_pkg::ADDR_FAULT_POS: read_word = w3;
      status_pkg::ADDR_SW_COUNT: read_word = w4;
      default: read_word = 16'h0000;
    endcase
  endfunction : read_word

  // Mode and frame decode
  assign in_init = mode == status_pkg::ST_INIT;
  assign in_run = mode == status_pkg::ST_RUN;
  assign in_error = mode == status_pkg::ST_ERROR;
  // Init waits so the sync chain has settled before capture
  assign init_done = init_cnt == 3'(status_pkg::INIT_CYCLES);
  assign frame_ok = i_frame_valid && !i_frame_bad;
  assign frame_fail = i_frame_valid && i_frame_bad;
  // Watchdog fires only on a frameless cycle, so a late frame still counts
  assign timer_limit = 32'(TIMEOUT_CYC) - 32'h0000_0001;
  assign timed_out = timer >= timer_limit;
  assign frame_lost = timed_out && !i_frame_valid;
  assign entering_error = next_mode == status_pkg::ST_ERROR;

  // Word store control
  assign store_load = frame_ok && in_run;
  // Zeroing starts in the entry cycle, so no stale guard bit is readable
  assign store_error = in_error || entering_error;
  assign count_load = in_init && init_done;

  // Request decode
  assign func_ok = i_req_func == status_pkg::FUNC_READ_HOLDING;
  assign addr_ok = in_map(i_req_addr);
  assign req_ok = i_req_valid && func_ok && addr_ok;
  assign sel_word = read_word(i_req_addr, words.guard_low, words.guard_high, words.fault_pos, words.sw_count);
  assign next_rsp_exception = i_req_valid && !(func_ok && addr_ok);
  assign next_rsp_data = req_ok ? sel_word : 16'h0000;

  // Mode sequencing; error is blocking, only reset leaves it
  always_comb begin
    next_mode = mode;
    case (mode)
      status_pkg::ST_INIT: begin
        if (init_done) begin
          next_mode = status_pkg::ST_RUN;
        end
      end
      status_pkg::ST_RUN: begin
        if (frame_fail || frame_lost) begin
          next_mode = status_pkg::ST_ERROR;
        end
      end
      status_pkg::ST_ERROR: begin
        next_mode = status_pkg::ST_ERROR;
      end
      default: begin
        next_mode = status_pkg::ST_INIT;
      end
    endcase
  end

  // Init counter parks at its end value
  always_comb begin
    next_init_cnt = init_cnt;
    if (!init_done) begin
      next_init_cnt = init_cnt + 3'h1;
    end
  end

  // Timer restarts on every frame and rests outside run
  always_comb begin
    next_timer = timer;
    if (!in_run || i_frame_valid) begin
      next_timer = 32'h0000_0000;
    end else if (!timed_out) begin
      next_timer = timer + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode <= status_pkg::ST_INIT;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      init_cnt <= 3'h0;
    end else begin
      init_cnt <= next_init_cnt;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      timer <= 32'h0000_0000;
    end else begin
      timer <= next_timer;
    end
  end

  // Own flop so the pin never shows decode glitches
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      error_mode <= 1'b0;
    end else begin
      error_mode <= entering_error;
    end
  end

  status_word_store u_store (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_load(store_load),
    .i_error(store_error),
    .i_closed(i_frame_closed),
    .i_fault_pos(i_frame_fault_pos),
    .i_count_load(count_load),
    .i_count(dip_stable),
    .words(words)
  );

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= i_req_valid;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rsp_exception <= 1'b0;
    end else begin
      rsp_exception <= next_rsp_exception;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rsp_data <= 16'h0000;
    end else begin
      rsp_data <= next_rsp_data;
    end
  end

  assign o_rsp_valid = rsp_valid;
  assign o_rsp_exception = rsp_exception;
  assign o_rsp_data = rsp_data;
  assign o_error_mode = error_mode;
endmodule : safety_chain_status_regs

// ===== dv/scsr_assertions.sv
module scsr_assertions (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_req_valid,
  input wire logic [7:0] i_req_func,
  input wire logic [15:0] i_req_addr,
  input wire logic o_rsp_valid,
  input wire logic o_rsp_exception,
  input wire logic [15:0] o_rsp_data,
  input wire logic o_error_mode
);
  timeunit 1ns / 1ns;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  wire go = i_req_valid && i_req_func == 8'h03;
  property p_rsp; i_req_valid |=> o_rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("rsp missing");
  property p_gap; !i_req_valid |=> !o_rsp_valid; endproperty
  a_gap: assert property (p_gap) else $error("rsp extra");
  property p_func; i_req_valid && !go |=> o_rsp_exception && o_rsp_data == 16'h0000; endproperty
  a_func: assert property (p_func) else $error("func");
  property p_hi; go && i_req_addr == 16'h0002 |=> o_rsp_data[15:4] == 12'h000; endproperty
  a_hi: assert property (p_hi) else $error("high word");
  property p_pos; go && i_req_addr == 16'h0003 |=> o_rsp_data[15:5] == 11'h000; endproperty
  a_pos: assert property (p_pos) else $error("fault word");
  property p_cnt; go && i_req_addr == 16'h0004 |=> o_rsp_data[15:5] == 11'h000; endproperty
  a_cnt: assert property (p_cnt) else $error("count word");
  property p_err; o_error_mode && go && i_req_addr == 16'h0001 |=> o_rsp_data == 16'h0000; endproperty
  a_err: assert property (p_err) else $error("guard in error");
  property p_stick; o_error_mode |=> o_error_mode; endproperty
  a_stick: assert property (p_stick) else $error("error left");
  c_exc: cover property (o_rsp_exception);
  c_err: cover property ($rose(o_error_mode));
  c_cnt: cover property (go && i_req_addr == 16'h0004);
endmodule : scsr_assertions
bind safety_chain_status_regs scsr_assertions u_chk (
  .i_sys_clk(i_sys_clk),
  .i_rstn(i_rstn),
  .i_req_valid(i_req_valid),
  .i_req_func(i_req_func),
  .i_req_addr(i_req_addr),
  .o_rsp_valid(o_rsp_valid),
  .o_rsp_exception(o_rsp_exception),
  .o_rsp_data(o_rsp_data),
  .o_error_mode(o_error_mode)
);

// ===== dv/modbus_master_model.sv
module modbus_master_model (
  input wire logic i_sys_clk,
  input wire logic i_rsp_valid,
  input wire logic i_rsp_exception,
  input wire logic [15:0] i_rsp_data,
  output logic o_req_valid,
  output logic [7:0] o_req_func,
  output logic [15:0] o_req_addr
);
  timeunit 1ns / 1ns;
  initial {o_req_valid, o_req_func, o_req_addr} = 25'h000_0000;
  task automatic read(input logic [7:0] f, input logic [15:0] a, output logic [16:0] r);
    @(posedge i_sys_clk);
    {o_req_valid, o_req_func, o_req_addr} <= {1'b1, f, a};
    @(posedge i_sys_clk);
    o_req_valid <= 1'b0;
    o_req_addr <= ~a;
    @(negedge i_sys_clk);
    // A missing answer shows as a word the design never returns
    r = i_rsp_valid ? {i_rsp_exception, i_rsp_data} : 17'h1_ffff;
  endtask : read
endmodule : modbus_master_model

// ===== dv/tb_safety_chain_status_regs.sv
module tb_safety_chain_status_regs;
  timeunit 1ns / 1ns;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [4:0] i_dip_count = 5'h0e;
  logic i_frame_valid = 1'b0;
  logic i_frame_bad = 1'b0;
  logic [19:0] i_frame_closed = 20'h0_0000;
  logic [4:0] i_frame_fault_pos = 5'h00;
  logic i_req_valid, o_rsp_valid, o_rsp_exception, o_error_mode;
  logic [7:0] i_req_func;
  logic [15:0] i_req_addr, o_rsp_data;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  localparam int TMO_CYC = 200;
  // Init count, the step into run, then the whole watchdog span
  localparam int TMO_EDGES = status_pkg::INIT_CYCLES + 1 + TMO_CYC;
  safety_chain_status_regs #(
    .TIMEOUT_CYC(TMO_CYC)
  ) u_dut (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_dip_count(i_dip_count),
    .i_frame_valid(i_frame_valid),
    .i_frame_bad(i_frame_bad),
    .i_frame_closed(i_frame_closed),
    .i_frame_fault_pos(i_frame_fault_pos),
    .i_req_valid(i_req_valid),
    .i_req_func(i_req_func),
    .i_req_addr(i_req_addr),
    .o_rsp_valid(o_rsp_valid),
    .o_rsp_exception(o_rsp_exception),
    .o_rsp_data(o_rsp_data),
    .o_error_mode(o_error_mode)
  );
  modbus_master_model u_m (
    .i_sys_clk(i_sys_clk),
    .i_rsp_valid(o_rsp_valid),
    .i_rsp_exception(o_rsp_exception),
    .i_rsp_data(o_rsp_data),
    .o_req_valid(i_req_valid),
    .o_req_func(i_req_func),
    .o_req_addr(i_req_addr)
  );
  task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_mode(input logic e);
    samples_checked++;
    if (o_error_mode !== e) begin
      fail_count++;
      $display("Error o_error_mode expected %b seen %b", e, o_error_mode);
    end
  endtask : chk_mode
  task automatic rd(input logic [7:0] f, input logic [15:0] a, input logic [16:0] e);
    logic [16:0] r;
    u_m.read(f, a, r);
    chk("word", e, r);
  endtask : rd
  task automatic fr(input logic b, input logic [19:0] c, input logic [4:0] p);
    @(posedge i_sys_clk);
    {i_frame_valid, i_frame_bad, i_frame_closed, i_frame_fault_pos} <= {1'b1, b, c, p};
    @(posedge i_sys_clk);
    {i_frame_valid, i_frame_closed} <= {1'b0, ~c};
    @(negedge i_sys_clk);
  endtask : fr
  task automatic t_init;
    rd(8'h03, 16'h0004, 17'h0_0000);
    rd(8'h03, 16'h0001, 17'h0_0000);
    repeat (9) @(posedge i_sys_clk);
    i_dip_count <= 5'h03;
    // Long enough for the new pins to pass the synchroniser
    repeat (6) @(posedge i_sys_clk);
    rd(8'h03, 16'h0004, 17'h0_000e);
  endtask : t_init
  task automatic t_frame;
    fr(1'b0, 20'ha_5c3b, 5'h14);
    rd(8'h03, 16'h0001, 17'h0_5c3b);
    rd(8'h03, 16'h0002, 17'h0_000a);
    rd(8'h03, 16'h0003, 17'h0_0014);
    fr(1'b0, 20'h5_0001, 5'h00);
    rd(8'h03, 16'h0001, 17'h0_0001);
    rd(8'h03, 16'h0002, 17'h0_0005);
    rd(8'h03, 16'h0003, 17'h0_0000);
  endtask : t_frame
  task automatic t_refuse;
    rd(8'h04, 16'h0001, 17'h1_0000);
    rd(8'h03, 16'h0000, 17'h1_0000);
    rd(8'h03, 16'h0005, 17'h1_0000);
  endtask : t_refuse
  task automatic t_bad;
    fr(1'b1, 20'hf_ffff, 5'h02);
    chk_mode(1'b1);
    rd(8'h03, 16'h0001, 17'h0_0000);
    rd(8'h03, 16'h0002, 17'h0_0000);
    fr(1'b0, 20'hf_ffff, 5'h00);
    chk_mode(1'b1);
    rd(8'h03, 16'h0001, 17'h0_0000);
  endtask : t_bad
  task automatic t_tmo;
    @(posedge i_sys_clk);
    i_rstn <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    repeat (TMO_EDGES) @(negedge i_sys_clk);
    chk_mode(1'b0);
    @(negedge i_sys_clk);
    chk_mode(1'b1);
  endtask : t_tmo
  task automatic close_out;
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      close_out;
    end
  end
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    t_init;
    t_frame;
    t_refuse;
    t_bad;
    t_tmo;
    close_out;
  end
endmodule : tb_safety_chain_status_regs
